// file: hdl/usd_pkg.sv
// usd_pkg: constants and types for the user/supervisor segment decoder
// assumes: apb register map with byte addresses, 64-bit virtual addresses
`default_nettype none
package usd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_EVT_STAT = 8'h04;
  localparam logic [7:0] OFF_EVT_MASK = 8'h08;
  localparam logic [7:0] OFF_LAST     = 8'h0C;
  localparam logic [7:0] OFF_ERR_LO   = 8'h10;
  localparam logic [7:0] OFF_ERR_HI   = 8'h14;
  // mode register fields
  localparam int unsigned MODE_PRIV_LSB = 0;
  localparam int unsigned MODE_EXL_BIT  = 2;
  localparam int unsigned MODE_ERL_BIT  = 3;
  localparam int unsigned MODE_UX_BIT   = 4;
  localparam int unsigned MODE_SX_BIT   = 5;
  localparam int unsigned MODE_KX_BIT   = 6;
  localparam int unsigned MODE_ADDRESS_SPACE_ID_LSB = 8;
  localparam logic [31:0] MODE_RST      = 32'h0000_0000;
  // event bits, shared by status and mask
  localparam int unsigned EVT_W        = 4;
  localparam int unsigned EVT_ADDR_ERR = 0;
  localparam int unsigned EVT_OVF      = 1;
  localparam int unsigned EVT_WMISS    = 2;
  localparam int unsigned EVT_NMISS    = 3;
  localparam logic [3:0]  EVT_RST      = 4'h0;
  // last-result register fields
  localparam int unsigned LAST_SEG_LSB  = 0;
  localparam int unsigned LAST_MODE_LSB = 4;
  localparam int unsigned LAST_MAP_BIT  = 8;
  localparam int unsigned LAST_ERR_BIT  = 9;
  localparam int unsigned LAST_OVF_BIT  = 10;
  // privilege field codes and segment matching
  localparam logic [1:0]  PRIV_KERNEL = 2'h0;
  localparam logic [1:0]  PRIV_SUPER  = 2'h1;
  localparam logic [1:0]  PRIV_USER   = 2'h2;
  localparam logic [1:0]  TOP2_XSUSEG = 2'h0;
  localparam logic [1:0]  TOP2_XSSEG  = 2'h1;
  localparam logic [2:0]  TOP3_SSEG   = 3'h6;
  localparam logic [31:0] CSSEG_HI    = 32'hFFFF_FFFF;
  localparam int unsigned XUSER_LSB   = 40;
  typedef enum logic [3:0] {
    SEG_NONE, SEG_USEG, SEG_XUSEG, SEG_SUSEG, SEG_SSEG,
    SEG_XSUSEG, SEG_XSSEG, SEG_CSSEG, SEG_KERNEL
  } usd_seg_t;
  typedef enum logic [1:0] {MODE_KERNEL, MODE_SUPER, MODE_USER, MODE_BAD} usd_mode_t;
endpackage : usd_pkg
`default_nettype wire

// file: hdl/usd_dec_if.sv
// usd_dec_if: status bits and address in, segment verdict out
// assumes: purely combinational path inside the pclk domain
`default_nettype none
interface usd_dec_if;
  logic [1:0]        priv;
  logic              exception_level_bit;
  logic              error_level_bit;
  logic              ux;
  logic              sx;
  logic              kx;
  logic [63:0]       base;
  logic [15:0]       offset;
  logic [63:0]       va;
  logic              ovf;
  logic              wide;
  usd_pkg::usd_seg_t  seg;
  usd_pkg::usd_mode_t mode;
  logic              err;
  logic              mapped;
  modport core (output priv, exception_level_bit, error_level_bit, ux, sx, kx, base, offset,
                input va, ovf, wide, seg, mode, err, mapped);
  modport dec  (input priv, exception_level_bit, error_level_bit, ux, sx, kx, base, offset,
                output va, ovf, wide, seg, mode, err, mapped);
endinterface : usd_dec_if
`default_nettype wire

// file: hdl/usd_seg_decode.sv
// usd_seg_decode: mode, width, effective address and segment match
// assumes: status bits stable for the cycle the address is presented
`default_nettype none
module usd_seg_decode (
  usd_dec_if.dec d
);
  logic        kern;
  logic [63:0] sum;
  logic        lo_clear;
  logic        user_ok;
  logic        sup_narrow;
  usd_pkg::usd_seg_t sup_seg;

  // kernel wins over everything else
  assign kern = (d.priv == usd_pkg::PRIV_KERNEL) | d.exception_level_bit | d.error_level_bit;
  assign d.mode = kern ? usd_pkg::MODE_KERNEL :
                  (d.priv == usd_pkg::PRIV_SUPER) ? usd_pkg::MODE_SUPER :
                  (d.priv == usd_pkg::PRIV_USER) ? usd_pkg::MODE_USER :
                  usd_pkg::MODE_BAD;
  assign d.wide = (d.mode == usd_pkg::MODE_SUPER) ? d.sx :
                  (d.mode == usd_pkg::MODE_USER) ? d.ux : d.kx;

  assign sum  = d.base + {{48{d.offset[15]}}, d.offset};
  // narrow addresses live as sign-extended 64-bit values
  assign d.va = d.wide ? sum : {{32{sum[31]}}, sum[31:0]};
  // result undefined on overflow; flagged, address still passed on
  assign d.ovf = ~d.wide & (d.offset[15] == d.base[31]) & (sum[31] != d.base[31]);

  assign lo_clear = (d.va[61:usd_pkg::XUSER_LSB] == '0);
  assign user_ok  = d.ux ? (d.va[63:usd_pkg::XUSER_LSB] == '0) : ~d.va[31];
  assign sup_narrow = ~d.sx;
  assign sup_seg =
    sup_narrow ? (~d.va[31] ? usd_pkg::SEG_SUSEG :
                  (d.va[31:29] == usd_pkg::TOP3_SSEG) ? usd_pkg::SEG_SSEG :
                  usd_pkg::SEG_NONE) :
    ((d.va[63:62] == usd_pkg::TOP2_XSUSEG) && lo_clear) ? usd_pkg::SEG_XSUSEG :
    ((d.va[63:62] == usd_pkg::TOP2_XSSEG) && lo_clear) ? usd_pkg::SEG_XSSEG :
    ((d.va[63:32] == usd_pkg::CSSEG_HI) && (d.va[31:29] == usd_pkg::TOP3_SSEG)) ?
      usd_pkg::SEG_CSSEG : usd_pkg::SEG_NONE;

  assign d.seg =
    (d.mode == usd_pkg::MODE_KERNEL) ? usd_pkg::SEG_KERNEL :
    (d.mode == usd_pkg::MODE_USER) ?
      (user_ok ? (d.ux ? usd_pkg::SEG_XUSEG : usd_pkg::SEG_USEG) : usd_pkg::SEG_NONE) :
    (d.mode == usd_pkg::MODE_SUPER) ? sup_seg : usd_pkg::SEG_NONE;
  assign d.err    = (d.seg == usd_pkg::SEG_NONE);
  assign d.mapped = ~d.err & (d.seg != usd_pkg::SEG_KERNEL);
endmodule : usd_seg_decode
`default_nettype wire

// file: hdl/usd_user_supervisor_decode.sv
// usd_user_supervisor_decode: apb-controlled user/supervisor segment decoder
// assumes: agen inputs and tlb miss synchronous to pclk; tlb miss refers to
// the most recent result
// Behaviour
// - wide user mode: address is user segment only when bits 63..40 are zero
// - wide user mode: any nonzero bit in 63..40 is an address error
// - tlb miss in wide user addressing goes to the wide miss vector
// - privilege 01 with exception and error bits clear is supervisor mode
// - supervisor width bit: 0 gives 32-bit, 1 gives 64-bit decoding
// - all supervisor segments are tlb mapped; cacheability comes from tlb
// - 32-bit supervisor: bit 31 clear selects mapped supervisor-user segment
// - 32-bit supervisor: top three bits 110 select 512 Mbyte segment
// - 64-bit supervisor: bits 63:62 = 00 select supervisor-user terabyte
// - 64-bit supervisor: bits 63:62 = 01 select current supervisor terabyte
// - 64-bit supervisor: bits 63:62 = 11 select separate 512 Mbyte segment
// - supervisor addresses carry the 8-bit address space id to the tlb
// - 32-bit addresses are bit 31 sign-extended into bits 63..32
// - base plus offset overflow detected from sign bits; result undefined
// - privilege 10 with exception and error bits clear is user mode
// - 32-bit user mode: bit 31 set is an address error
// - privilege 00 or exception or error bit gives kernel mode, first
`default_nettype none
module usd_user_supervisor_decode #(
  parameter int unsigned ADDRESS_SPACE_ID_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire logic [63:0] req_base,
  input  wire logic [15:0] req_offset,
  input  wire logic        tlb_miss,
  output logic             res_valid,
  output logic [3:0]       res_seg,
  output logic             res_mapped,
  output logic             res_addr_err,
  output logic             res_overflow,
  output logic             res_kernel,
  output logic [71:0]      res_tlb_key,
  output logic             wide_tlb_miss_vector,
  output logic             narrow_tlb_miss_vector,
  output logic             irq
);
  if (ADDRESS_SPACE_ID_W < 1 || ADDRESS_SPACE_ID_W > 8) begin : g_address_space_id_chk
    $error("ADDRESS_SPACE_ID_W must be 1..8");
  end

  function automatic logic [31:0] usd_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return r;
  endfunction : usd_merge

  usd_dec_if dec ();
  usd_seg_decode u_dec (
    .d (dec)
  );

  logic [31:0]      mode_r;
  logic [31:0]      mode_nxt;
  logic [3:0]       stat_r;
  logic [3:0]       stat_nxt;
  logic [3:0]       mask_r;
  logic [3:0]       mask_nxt;
  logic [63:0]      err_va_r;
  logic             res_wide_r;
  logic [1:0]       res_mode_r;
  logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
  logic [3:0]       evt;
  logic [3:0]       clr;
  logic [31:0]      last_word;
  logic [31:0]      rd_mux;

  // apb decode
  wire logic acc      = psel & penable;
  wire logic wr       = acc & pwrite;
  wire logic hit_mode = (paddr == usd_pkg::OFF_MODE);
  wire logic hit_stat = (paddr == usd_pkg::OFF_EVT_STAT);
  wire logic hit_mask = (paddr == usd_pkg::OFF_EVT_MASK);
  wire logic hit_last = (paddr == usd_pkg::OFF_LAST);
  wire logic hit_elo  = (paddr == usd_pkg::OFF_ERR_LO);
  wire logic hit_ehi  = (paddr == usd_pkg::OFF_ERR_HI);
  wire logic hit_any  = hit_mode | hit_stat | hit_mask | hit_last | hit_elo | hit_ehi;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  assign mode_nxt = (wr & hit_mode) ? usd_merge(mode_r, pwdata, pstrb) : mode_r;
  wire logic [31:0] mask_wr = usd_merge({28'h0, mask_r}, pwdata, pstrb);
  assign mask_nxt = (wr & hit_mask) ? mask_wr[3:0] : mask_r;
  assign clr      = (wr & hit_stat & pstrb[0]) ? pwdata[3:0] : 4'h0;

  // status bits feed the decoder straight from the mode register
  assign dec.priv   = mode_r[usd_pkg::MODE_PRIV_LSB +: 2];
  assign dec.exception_level_bit    = mode_r[usd_pkg::MODE_EXL_BIT];
  assign dec.error_level_bit    = mode_r[usd_pkg::MODE_ERL_BIT];
  assign dec.ux     = mode_r[usd_pkg::MODE_UX_BIT];
  assign dec.sx     = mode_r[usd_pkg::MODE_SX_BIT];
  assign dec.kx     = mode_r[usd_pkg::MODE_KX_BIT];
  assign dec.base   = req_base;
  assign dec.offset = req_offset;
  assign address_space_id       = mode_r[usd_pkg::MODE_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_W];

  // events: set wins over a same-cycle clear
  assign evt[usd_pkg::EVT_ADDR_ERR] = req_valid & dec.err;
  assign evt[usd_pkg::EVT_OVF]      = req_valid & dec.ovf;
  assign evt[usd_pkg::EVT_WMISS]    = tlb_miss & res_valid & res_wide_r;
  assign evt[usd_pkg::EVT_NMISS]    = tlb_miss & res_valid & ~res_wide_r;
  assign stat_nxt = (stat_r & ~clr) | evt;
  assign irq      = |(stat_r & mask_r);

  assign last_word = {21'h0, res_overflow, res_addr_err, res_mapped,
                      2'h0, res_mode_r, res_seg};
  assign rd_mux = hit_mode ? mode_r :
                  hit_stat ? {28'h0, stat_r} :
                  hit_mask ? {28'h0, mask_r} :
                  hit_last ? last_word :
                  hit_elo  ? err_va_r[31:0] :
                  hit_ehi  ? err_va_r[63:32] : 32'h0;
  assign prdata = (acc & ~pwrite) ? rd_mux : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r   <= usd_pkg::MODE_RST;
      stat_r   <= usd_pkg::EVT_RST;
      mask_r   <= usd_pkg::EVT_RST;
      err_va_r <= 64'h0;
    end else begin
      mode_r   <= mode_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      if (evt[usd_pkg::EVT_ADDR_ERR]) begin
        err_va_r <= dec.va;
      end
    end
  end

  // one result per request, one cycle after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid    <= 1'b0;
      res_seg      <= 4'h0;
      res_mapped   <= 1'b0;
      res_addr_err <= 1'b0;
      res_overflow <= 1'b0;
      res_kernel   <= 1'b0;
      res_tlb_key  <= 72'h0;
      res_wide_r   <= 1'b0;
      res_mode_r   <= 2'h0;
    end else begin
      res_valid <= req_valid;
      if (req_valid) begin
        res_seg      <= dec.seg;
        res_mapped   <= dec.mapped;
        res_addr_err <= dec.err;
        res_overflow <= dec.ovf;
        res_kernel   <= (dec.mode == usd_pkg::MODE_KERNEL);
        res_tlb_key  <= {8'(address_space_id), dec.va};
        res_wide_r   <= dec.wide;
        res_mode_r   <= dec.mode;
      end
    end
  end

  // vector choice follows the width of the access that missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_tlb_miss_vector   <= 1'b0;
      narrow_tlb_miss_vector <= 1'b0;
    end else begin
      wide_tlb_miss_vector   <= evt[usd_pkg::EVT_WMISS];
      narrow_tlb_miss_vector <= evt[usd_pkg::EVT_NMISS];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic [63:0] va   = dec.va;
  wire logic        usr  = ~dec.priv[0] & dec.priv[1] & ~dec.exception_level_bit & ~dec.error_level_bit;
  wire logic        sup  = dec.priv[0] & ~dec.priv[1] & ~dec.exception_level_bit & ~dec.error_level_bit;

  a_xuser_seg_ok : assert property (
    req_valid && usr && dec.ux && va[63:40] == 24'h0
    |=> res_seg == usd_pkg::SEG_XUSEG && !res_addr_err)
    else $error("wide user address not accepted");
  a_xuser_seg_err : assert property (
    req_valid && usr && dec.ux && va[63:40] != 24'h0
    |=> res_addr_err && !res_mapped && stat_r[usd_pkg::EVT_ADDR_ERR])
    else $error("wide user error missing");
  a_user_width : assert property (
    req_valid && usr |-> dec.wide == dec.ux)
    else $error("user width wrong");
  a_miss_wide_vec : assert property (
    res_valid && tlb_miss && res_wide_r
    |=> wide_tlb_miss_vector && !narrow_tlb_miss_vector)
    else $error("wide miss vector not used");
  a_super_mode_sel : assert property (
    req_valid && dec.priv == 2'h1 && !dec.exception_level_bit && !dec.error_level_bit
    |-> dec.mode == usd_pkg::MODE_SUPER)
    else $error("supervisor mode not taken");
  a_super_width : assert property (
    req_valid && sup |-> dec.wide == dec.sx)
    else $error("supervisor width wrong");
  a_super_mapped : assert property (
    req_valid && sup && !dec.err |=> res_mapped && !res_kernel)
    else $error("supervisor segment not mapped");
  a_suseg_sel : assert property (
    req_valid && sup && !dec.sx && !va[31] |=> res_seg == usd_pkg::SEG_SUSEG)
    else $error("suseg not selected");
  a_sseg_sel : assert property (
    req_valid && sup && !dec.sx && va[31:29] == 3'h6
    |=> res_seg == usd_pkg::SEG_SSEG)
    else $error("sseg not selected");
  a_xsuseg_sel : assert property (
    req_valid && sup && dec.sx && va <= 64'h0000_00FF_FFFF_FFFF
    |=> res_seg == usd_pkg::SEG_XSUSEG)
    else $error("xsuseg not selected");
  a_xsseg_sel : assert property (
    req_valid && sup && dec.sx && va >= 64'h4000_0000_0000_0000
    && va <= 64'h4000_00FF_FFFF_FFFF |=> res_seg == usd_pkg::SEG_XSSEG)
    else $error("xsseg not selected");
  a_csseg_sel : assert property (
    req_valid && sup && dec.sx && va >= 64'hFFFF_FFFF_C000_0000
    && va <= 64'hFFFF_FFFF_DFFF_FFFF |=> res_seg == usd_pkg::SEG_CSSEG)
    else $error("csseg not selected");
  a_address_space_id_key : assert property (
    req_valid |=> res_tlb_key[71:64] == 8'($past(address_space_id)))
    else $error("address_space_id not attached");
  a_narrow_sext : assert property (
    req_valid && !dec.wide
    |=> res_tlb_key[63:32] == {32{res_tlb_key[31]}})
    else $error("narrow address not sign extended");
  a_ovf_flag : assert property (
    req_valid && !dec.wide && req_offset[15] == req_base[31]
    && dec.va[31] != req_base[31] |=> res_overflow)
    else $error("overflow not flagged");
  a_user_mode_sel : assert property (
    req_valid && usr |-> dec.mode == usd_pkg::MODE_USER)
    else $error("user mode not taken");
  a_user32_err : assert property (
    req_valid && usr && !dec.ux && va[31] |=> res_addr_err)
    else $error("narrow user error missing");
  a_kernel_first : assert property (
    req_valid && (dec.exception_level_bit || dec.error_level_bit || dec.priv == 2'h0)
    |=> res_kernel && !res_addr_err && res_seg == usd_pkg::SEG_KERNEL)
    else $error("kernel precedence lost");
  a_super_outside : assert property (
    req_valid && sup && dec.seg == usd_pkg::SEG_NONE
    |=> res_addr_err && !res_mapped)
    else $error("supervisor hole not an error");
  a_irq_level : assert property (
    stat_r[0] && mask_r[0] |-> irq)
    else $error("irq not raised");
endmodule : usd_user_supervisor_decode
`default_nettype wire

// file: verification/usd_far_model.sv
// usd_far_model: tlb side of the decoder, reports a miss on the result when told to
// assumes: one result per request, shown one pclk cycle after the request
`default_nettype none
module usd_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic req_valid,
  input  wire logic miss_cmd,
  output var  logic tlb_miss
);
  timeunit 1ns;
  timeprecision 1ps;
  // miss only ever stands beside res_valid, never alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlb_miss <= 1'b0;
    end else begin
      tlb_miss <= req_valid & miss_cmd;
    end
  end
endmodule : usd_far_model
`default_nettype wire

// file: verification/user_supervisor_segment_decode_bench.sv
// user_supervisor_segment_decode_bench: apb driver, request driver, queued result checks
// assumes: decoder answers one cycle after each request, apb slave with zero wait
`default_nettype none
module user_supervisor_segment_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  seg;
    logic        err;
    logic        ovf;
    logic        kern;
    logic        map;
    logic        miss;
    logic        wide;
    logic [71:0] key;
  } usd_note_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        req_valid = 1'b0;
  logic [63:0] req_base = 64'h0;
  logic [15:0] req_offset = 16'h0;
  logic        miss_cmd = 1'b0;
  logic        tlb_miss;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        res_valid;
  logic [3:0]  res_seg;
  logic        res_mapped;
  logic        res_addr_err;
  logic        res_overflow;
  logic        res_kernel;
  logic [71:0] res_tlb_key;
  logic        wide_tlb_miss_vector;
  logic        narrow_tlb_miss_vector;
  logic        irq;
  logic [31:0] mode_r = 32'h0;
  logic [63:0] b;
  int          seed;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  usd_note_t   q[$];
  usd_note_t   cur;
  logic        pend = 1'b0;
  logic        pend_wide = 1'b0;
  logic [31:0] modes [8] = '{32'h5A02, 32'h3C12, 32'hA501, 32'hC321, 32'h0070, 32'h0035,
                             32'h0069, 32'h7703};
  logic [63:0] addrs [15] = '{64'h0, 64'h7FFF_FFFF, 64'hFFFF_FFFF_8000_0000,
    64'hFFFF_FFFF_BFFF_FFFF, 64'hFFFF_FFFF_C000_0000, 64'hFFFF_FFFF_DFFF_FFFF,
    64'hFFFF_FFFF_E000_0000, 64'hFF_FFFF_FFFF, 64'h100_0000_0000, 64'h3FFF_FFFF_FFFF_FFFF,
    64'h4000_0000_0000_0000, 64'h4000_00FF_FFFF_FFFF, 64'h4000_0100_0000_0000,
    64'h8000_0000_0000_0000, 64'hC000_0000};

  usd_user_supervisor_decode usd_user_supervisor_decode_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_base(req_base),
    .req_offset(req_offset), .tlb_miss(tlb_miss), .res_valid(res_valid),
    .res_seg(res_seg), .res_mapped(res_mapped), .res_addr_err(res_addr_err),
    .res_overflow(res_overflow), .res_kernel(res_kernel), .res_tlb_key(res_tlb_key),
    .wide_tlb_miss_vector(wide_tlb_miss_vector),
    .narrow_tlb_miss_vector(narrow_tlb_miss_vector), .irq(irq));
  usd_far_model usd_far_model_i (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
    .miss_cmd(miss_cmd), .tlb_miss(tlb_miss));

  always #5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // expected verdict worked out from the mode word, never from the design
  function automatic usd_note_t predict(input logic [31:0] m, input logic [63:0] bs,
                                        input logic [15:0] o, input logic mi);
    usd_note_t   n;
    logic [63:0] s;
    logic [63:0] va;
    n = '0;
    s = bs + {{48{o[15]}}, o};
    n.kern = (m[1:0] == 2'h0) || m[2] || m[3];
    n.wide = (n.kern || m[1:0] == 2'h3) ? m[6] : (m[1:0] == 2'h1 ? m[5] : m[4]);
    va = n.wide ? s : {{32{s[31]}}, s[31:0]};
    n.ovf = !n.wide && (o[15] == bs[31]) && (s[31] != o[15]);
    n.key = {m[15:8], va};
    n.miss = mi;
    if (n.kern) n.seg = usd_pkg::SEG_KERNEL;
    else if (m[1:0] == 2'h3) n.seg = usd_pkg::SEG_NONE; // privilege 11 is refused
    else if (m[1:0] == 2'h2 && !n.wide)
      n.seg = va[31] ? usd_pkg::SEG_NONE : usd_pkg::SEG_USEG;
    else if (m[1:0] == 2'h2)
      n.seg = va[63:40] == 24'h0 ? usd_pkg::SEG_XUSEG : usd_pkg::SEG_NONE;
    else if (!n.wide)
      n.seg = !va[31] ? usd_pkg::SEG_SUSEG :
              va[31:29] == 3'h6 ? usd_pkg::SEG_SSEG : usd_pkg::SEG_NONE;
    else if (va[63:62] == 2'h0)
      n.seg = va[61:40] == 22'h0 ? usd_pkg::SEG_XSUSEG : usd_pkg::SEG_NONE;
    else if (va[63:62] == 2'h1)
      n.seg = va[61:40] == 22'h0 ? usd_pkg::SEG_XSSEG : usd_pkg::SEG_NONE;
    else if (va[63:62] == 2'h3 && va[61:29] == 33'h1_FFFF_FFFE)
      n.seg = usd_pkg::SEG_CSSEG;
    n.err = !n.kern && n.seg == usd_pkg::SEG_NONE;
    n.map = !n.kern && !n.err;
    return n;
  endfunction : predict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk("prdata", rd, exp);
    chk("pslverr", er, ee);
  endtask : rchk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    chk("pslverr", er, ee);
    if (a == usd_pkg::OFF_MODE) mode_r = d;
  endtask : wr

  task automatic dec(input logic [63:0] bs, input logic [15:0] o, input logic mi);
    @(posedge pclk);
    req_valid  <= 1'b1;
    req_base   <= bs;
    req_offset <= o;
    miss_cmd   <= mi;
    q.push_back(predict(mode_r, bs, o, mi));
  endtask : dec

  task automatic idle;
    @(posedge pclk);
    req_valid <= 1'b0;
    miss_cmd  <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : idle

  // result monitor: oldest note against what the decoder shows
  always @(posedge pclk) begin
    if (presetn) begin
      chk("wide_vec", wide_tlb_miss_vector, pend & pend_wide);
      chk("narrow_vec", narrow_tlb_miss_vector, pend & !pend_wide);
    end
    pend = 1'b0;
    if (res_valid === 1'b1 && q.size() == 0) chk("res_valid", 1'b1, 1'b0);
    else if (res_valid === 1'b1) begin
      cur = q.pop_front();
      pend = cur.miss;
      pend_wide = cur.wide;
      chk("err", res_addr_err, cur.err);
      chk("kernel", res_kernel, cur.kern);
      chk("ovf", res_overflow, cur.ovf);
      chk("seg", res_seg, cur.seg);
      chk("mapped", res_mapped, cur.map);
      if (!cur.err && !cur.kern) chk("key", res_tlb_key, cur.key);
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    seed = 429;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(usd_pkg::OFF_MODE, 32'h0, 1'b0);
    rchk(usd_pkg::OFF_EVT_STAT, 32'h0, 1'b0);
    rchk(usd_pkg::OFF_EVT_MASK, 32'h0, 1'b0);
    rchk(8'h20, 32'h0, 1'b1);
    wr(8'h20, 32'hFFFF_FFFF, 1'b1);
    wr(usd_pkg::OFF_MODE, 32'h5A02, 1'b0);
    dec(64'hFFFF_FFFF_8000_0000, 16'h0000, 1'b0);
    idle();
    rchk(usd_pkg::OFF_EVT_STAT, 32'h1, 1'b0);
    rchk(usd_pkg::OFF_LAST, 32'h0000_0220, 1'b0);
    rchk(usd_pkg::OFF_ERR_LO, 32'h8000_0000, 1'b0);
    rchk(usd_pkg::OFF_ERR_HI, 32'hFFFF_FFFF, 1'b0);
    chk("irq", irq, 1'b0);
    wr(usd_pkg::OFF_EVT_MASK, 32'h1, 1'b0);
    #1 chk("irq", irq, 1'b1);
    wr(usd_pkg::OFF_EVT_STAT, 32'h1, 1'b0);
    #1 chk("irq", irq, 1'b0);
    rchk(usd_pkg::OFF_EVT_STAT, 32'h0, 1'b0);
    foreach (modes[m]) begin
      wr(usd_pkg::OFF_MODE, modes[m], 1'b0);
      foreach (addrs[k]) dec(addrs[k], 16'h0000, k == 0);
      dec(64'h7FFF_FFF0, 16'h0020, 1'b0);
      dec(64'hFFFF_FFFF_8000_0010, 16'h8000, 1'b0);
      repeat (8) begin
        b = {$random(seed), $random(seed)};
        if (b[0]) b = {{32{b[31]}}, b[31:0]};
        dec(b, 16'($random(seed)), 1'b0);
      end
      idle();
    end
    chk("queue_left", 72'(q.size()), 72'h0);
    close_out();
  end
endmodule : user_supervisor_segment_decode_bench
`default_nettype wire
